// ### src/wws_supervisor.sv
`timescale 1ns/10ps
`default_nettype none
`include "wws_consts.svh"
module wws_supervisor (
    input wire logic REF_CLK,
    input wire logic ARST_N,
    input wire logic WATCHDOG_STROBE_IN,
    input wire logic SUPPLY_MONITOR_IN,
    input wire logic WDOG_DISABLE_IN,
    output logic HOST_RESET_N,
    output logic BACKUP_FLAG_N
);
    localparam logic [`WWS_CNT_W-1:0] WDOG_CYC = (`WWS_CNT_W)'(`WWS_WDOG_CYCLES);
    localparam logic [`WWS_CNT_W-1:0] RST_CYC = (`WWS_CNT_W)'(`WWS_RESET_CYCLES);
    // closed window is the remainder of the period
    localparam logic [`WWS_CNT_W-1:0] CLOSED_CYC = (`WWS_CNT_W)'(
        (`WWS_WDOG_CYCLES * (`WWS_QUARTERS - `WWS_OPEN_QUARTERS)) / `WWS_QUARTERS);

    ////////////////////////////////////////////////////////////////////////////
    logic strobe_fall;
    logic supply_meta_reg;
    logic supply_ok_reg;
    logic strap_meta_reg;
    logic strap_reg;
    wws_pkg::wws_state_t state_reg;
    logic [`WWS_CNT_W-1:0] wd_cnt_reg;
    logic [`WWS_CNT_W-1:0] rst_cnt_reg;
    logic [1:0] bad_cnt_reg;
    logic [1:0] good_cnt_reg;
    logic flag_reg;
    logic early_fault;
    logic late_fault;
    logic good_edge;
    logic bad_event;

    // strobe passes two flops then an edge detector
    wws_strobe_sync u_sync (
        .clk(REF_CLK),
        .arst_n(ARST_N),
        .pin_in(WATCHDOG_STROBE_IN),
        .fall_pulse(strobe_fall)
    );

    // level pins from outside are synchronised too
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            supply_meta_reg <= 1'b0;
            supply_ok_reg <= 1'b0;
            strap_meta_reg <= 1'b0;
            strap_reg <= 1'b0;
        end else begin
            supply_meta_reg <= SUPPLY_MONITOR_IN;
            supply_ok_reg <= supply_meta_reg;
            strap_meta_reg <= WDOG_DISABLE_IN;
            strap_reg <= strap_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // classification only while running; edges in hold are dropped
    // an edge on the exact boundary cycle counts as good
    always_comb begin
        early_fault = 1'b0;
        late_fault = 1'b0;
        good_edge = 1'b0;
        if (state_reg == wws_pkg::WWS_ST_RUN && supply_ok_reg && !strap_reg) begin
            if (strobe_fall) begin
                if (wd_cnt_reg < CLOSED_CYC) begin
                    early_fault = 1'b1;
                end else begin
                    good_edge = 1'b1;
                end
            end else if (wd_cnt_reg >= WDOG_CYC - `WWS_ONE_CNT) begin
                late_fault = 1'b1;
            end
        end
    end
    assign bad_event = early_fault | late_fault;

    // reset sequencer: hold while undervoltage or timing out the pulse
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_reg <= wws_pkg::WWS_ST_HOLD;
            rst_cnt_reg <= `WWS_ZERO_CNT;
        end else begin
            case (state_reg)
                wws_pkg::WWS_ST_HOLD: begin
                    if (!supply_ok_reg) begin
                        rst_cnt_reg <= `WWS_ZERO_CNT;
                    end else if (rst_cnt_reg >= RST_CYC - `WWS_ONE_CNT) begin
                        rst_cnt_reg <= `WWS_ZERO_CNT;
                        state_reg <= wws_pkg::WWS_ST_RUN;
                    end else begin
                        rst_cnt_reg <= rst_cnt_reg + `WWS_ONE_CNT;
                    end
                end
                wws_pkg::WWS_ST_RUN: begin
                    // faults and undervoltage both drop into hold
                    if (!supply_ok_reg || bad_event) begin
                        state_reg <= wws_pkg::WWS_ST_HOLD;
                    end
                    rst_cnt_reg <= `WWS_ZERO_CNT;
                end
                default: begin
                    state_reg <= wws_pkg::WWS_ST_HOLD;
                    rst_cnt_reg <= `WWS_ZERO_CNT;
                end
            endcase
        end
    end

    // watchdog timer; zero during hold, so release starts from zero
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            wd_cnt_reg <= `WWS_ZERO_CNT;
        end else if (state_reg != wws_pkg::WWS_ST_RUN || bad_event || !supply_ok_reg) begin
            wd_cnt_reg <= `WWS_ZERO_CNT;
        end else if (strap_reg) begin
            wd_cnt_reg <= `WWS_ZERO_CNT; // disabled: no faults can mature
        end else if (good_edge) begin
            wd_cnt_reg <= `WWS_ZERO_CNT;
        end else begin
            wd_cnt_reg <= wd_cnt_reg + `WWS_ONE_CNT;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // consecutive bad/good counters drive the backup flag
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            bad_cnt_reg <= 2'h0;
            good_cnt_reg <= 2'h0;
            flag_reg <= 1'b0;
        end else if (bad_event) begin
            good_cnt_reg <= 2'h0;
            if (bad_cnt_reg != `WWS_BAD_LIMIT) begin
                bad_cnt_reg <= bad_cnt_reg + 2'h1;
            end
            if (bad_cnt_reg == `WWS_BAD_LIMIT - 2'h1) begin
                flag_reg <= 1'b1;
            end
        end else if (good_edge) begin
            bad_cnt_reg <= 2'h0;
            if (flag_reg) begin
                if (good_cnt_reg == `WWS_GOOD_LIMIT - 2'h1) begin
                    flag_reg <= 1'b0;
                    good_cnt_reg <= 2'h0;
                end else begin
                    good_cnt_reg <= good_cnt_reg + 2'h1;
                end
            end
        end
    end

    // flag masked during undervoltage rather than lost
    assign HOST_RESET_N = (state_reg == wws_pkg::WWS_ST_RUN);
    assign BACKUP_FLAG_N = ~(flag_reg & supply_ok_reg);

    ////////////////////////////////////////////////////////////////////////////
    sequence s_early;
        strobe_fall && state_reg == wws_pkg::WWS_ST_RUN && supply_ok_reg && !strap_reg
            && wd_cnt_reg < CLOSED_CYC;
    endsequence
    sequence s_late;
        state_reg == wws_pkg::WWS_ST_RUN && supply_ok_reg && !strap_reg && !strobe_fall
            && wd_cnt_reg >= WDOG_CYC - `WWS_ONE_CNT;
    endsequence

    AST_EARLY_RESET: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        s_early |=> !HOST_RESET_N) else $error("early edge did not assert reset");
    AST_LATE_RESET: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        s_late |=> !HOST_RESET_N) else $error("timeout did not assert reset");
    AST_GOOD_KEEP: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        good_edge && supply_ok_reg |=> HOST_RESET_N && wd_cnt_reg == `WWS_ZERO_CNT)
        else $error("good edge disturbed reset");
    AST_TIMER_HELD: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        !HOST_RESET_N |-> wd_cnt_reg == `WWS_ZERO_CNT) else $error("timer ran during reset");
    AST_UV_HOLD: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        !supply_ok_reg |=> !HOST_RESET_N) else $error("reset released in undervoltage");
    AST_RELEASE_DELAY: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        $rose(HOST_RESET_N) |-> $past(rst_cnt_reg) == RST_CYC - `WWS_ONE_CNT)
        else $error("reset released before delay");
    AST_NO_FLAG_UV: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        !supply_ok_reg |-> BACKUP_FLAG_N) else $error("flag during undervoltage");
    AST_FLAG_RISE: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        $rose(flag_reg) |-> $past(bad_event) && $past(bad_cnt_reg) == 2'h2)
        else $error("flag rose without three bad events");
    AST_FLAG_FALL: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        $fell(flag_reg) |-> $past(good_edge) && $past(good_cnt_reg) == 2'h2)
        else $error("flag fell without three good edges");
    AST_IGNORE_IN_RESET: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        strobe_fall && !HOST_RESET_N |-> !good_edge && !bad_event)
        else $error("edge counted during reset");
    AST_STRAP: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        strap_reg |-> !bad_event) else $error("fault while disabled");
    AST_OPEN_IS_GOOD: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        strobe_fall && state_reg == wws_pkg::WWS_ST_RUN && supply_ok_reg && !strap_reg
            && wd_cnt_reg >= CLOSED_CYC |-> good_edge)
        else $error("open-window edge not taken as good");
    AST_RESTART_ZERO: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        $rose(HOST_RESET_N) |-> wd_cnt_reg == `WWS_ZERO_CNT)
        else $error("timer not zero at reset release");
    AST_FLAG_STEADY: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        !bad_event && !good_edge |=> $stable(flag_reg))
        else $error("flag moved without an event");
endmodule : wws_supervisor
`default_nettype wire

// ### shared/wws_consts.svh
`ifndef WWS_CONSTS_SVH
`define WWS_CONSTS_SVH
// timing figures, device clock is 100 MHz
// short periods keep a full fault sequence within a brief run; scale up for real use
`define WWS_CLK_PERIOD_NS 10
`define WWS_WDOG_PERIOD_US 1
`define WWS_RESET_DELAY_US 1
`define WWS_WDOG_CYCLES ((`WWS_WDOG_PERIOD_US * 1000) / `WWS_CLK_PERIOD_NS)
`define WWS_RESET_CYCLES ((`WWS_RESET_DELAY_US * 1000) / `WWS_CLK_PERIOD_NS)
// open window in quarters of the period: 2 = half, 3 = three quarters
`define WWS_OPEN_QUARTERS 3
`define WWS_QUARTERS 4
`define WWS_CNT_W 24
`define WWS_BAD_LIMIT 2'h3
`define WWS_GOOD_LIMIT 2'h3
`define WWS_ZERO_CNT 24'h000000
`define WWS_ONE_CNT 24'h000001
`endif

// ### shared/wws_pkg.sv
package wws_pkg;
    typedef enum logic [1:0] {
        WWS_ST_HOLD = 2'b00,
        WWS_ST_RUN = 2'b01
    } wws_state_t;
endpackage : wws_pkg

// ### src/wws_strobe_sync.sv
`timescale 1ns/10ps
`default_nettype none
// two-stage synchroniser plus falling-edge pulse for the strobe pin
module wws_strobe_sync (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic pin_in,
    output logic fall_pulse
);
    logic meta_reg;
    logic sync_reg;
    logic last_reg;

    // first stage feeds only the second stage
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_reg <= 1'b1;
            sync_reg <= 1'b1;
            last_reg <= 1'b1;
        end else begin
            meta_reg <= pin_in;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    // one-cycle pulse on high to low
    assign fall_pulse = last_reg & ~sync_reg;
endmodule : wws_strobe_sync
`default_nettype wire

// ### testbench/wws_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// stand-in for the supervised microcontroller
module wws_host_model (
    input wire logic clk,
    output logic strobe
);
    // steady high between services, never left toggling
    initial strobe = 1'b1;
    ////////////////////////////////////////
    // one falling edge n cycles from now; n in the open window is a
    // normal service, an earlier n provokes a fault on purpose
    task automatic service_after(input int n);
        repeat (n) @(posedge clk);
        #1 strobe = 1'b0;
        repeat (4) @(posedge clk);
        #1 strobe = 1'b1;
    endtask : service_after
endmodule : wws_host_model
`default_nettype wire

// ### testbench/test_window_watchdog_supervisor.sv
`timescale 1ns/10ps
`default_nettype none
`include "wws_consts.svh"
module test_window_watchdog_supervisor;
    localparam int WDOG = `WWS_WDOG_CYCLES;
    localparam int RST = `WWS_RESET_CYCLES;
    localparam int CLOSED = WDOG * (`WWS_QUARTERS - `WWS_OPEN_QUARTERS) / `WWS_QUARTERS;
    // mid open window, clear of both window boundaries
    localparam int GOOD_AT = (CLOSED + WDOG) / 2;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic supply_ok = 1'b0;
    logic wdog_off = 1'b0;
    logic strobe;
    logic host_reset_n;
    logic backup_flag_n;
    logic saw_low = 1'b0;
    int n_errors = 0;
    int comparisons = 0;
    int n;
    ////////////////////////////////////////
    // 100 MHz clock
    always #5 ref_clk = ~ref_clk;
    // remembers any reset pulse while a scenario watches
    always @(posedge ref_clk) if (host_reset_n === 1'b0) saw_low <= 1'b1;

    wws_supervisor u_dut (
        .REF_CLK(ref_clk), .ARST_N(arst_n), .WATCHDOG_STROBE_IN(strobe),
        .SUPPLY_MONITOR_IN(supply_ok), .WDOG_DISABLE_IN(wdog_off),
        .HOST_RESET_N(host_reset_n), .BACKUP_FLAG_N(backup_flag_n)
    );
    wws_host_model u_host (.clk(ref_clk), .strobe(strobe));
    ////////////////////////////////////////
    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input logic seen, input logic expd, input string what);
        comparisons++;
        if (seen !== expd) begin
            n_errors++;
            $display("MISMATCH at %0t: %s", $time, what);
        end
    endtask : check

    // bounded wait for a reset level, cycles left in n
    task automatic wait_rst(input logic lvl, input int bound);
        n = 0;
        while (host_reset_n !== lvl) begin
            @(posedge ref_clk);
            #1;
            n++;
            if (n > bound) begin
                check(1'b0, 1'b1, "reset level not reached");
                give_verdict();
            end
        end
    endtask : wait_rst
    ////////////////////////////////////////
    task automatic sc_power_up();
        repeat (50) @(posedge ref_clk);
        #1;
        check(host_reset_n, 1'b0, "released under low supply");
        check(backup_flag_n, 1'b1, "flag under low supply");
        supply_ok = 1'b1;
        wait_rst(1'b1, RST + 10);
        check(n >= RST && n <= RST + 4, 1'b1, "power-up reset length");
    endtask : sc_power_up

    // three services whose sum exceeds a period: only cleared timers survive
    task automatic sc_good();
        saw_low = 1'b0;
        repeat (3) u_host.service_after(GOOD_AT);
        repeat (2) @(posedge ref_clk);
        #1;
        check(saw_low, 1'b0, "good service raised reset");
        check(backup_flag_n, 1'b1, "flag after good run");
    endtask : sc_good

    task automatic sc_early();
        u_host.service_after(CLOSED / 2);
        wait_rst(1'b0, 4);
        repeat (2) u_host.service_after(10);
        wait_rst(1'b1, RST + 10);
        check(n + 28 >= RST - 1 && n + 28 <= RST + 3, 1'b1, "early reset length");
    endtask : sc_early

    // two lateness faults after the early one: third bad event sets the flag
    task automatic sc_late();
        for (int i = 2; i <= 3; i++) begin
            wait_rst(1'b0, WDOG + 10);
            check(n >= WDOG - 2 && n <= WDOG + 3, 1'b1, "late fault time");
            repeat (3) @(posedge ref_clk);
            #1;
            check(backup_flag_n, (i == 3) ? 1'b0 : 1'b1, "flag after bad run");
            wait_rst(1'b1, RST + 10);
            check(n >= RST - 6 && n <= RST + 2, 1'b1, "late reset length");
        end
    endtask : sc_late

    task automatic sc_uv();
        supply_ok = 1'b0;
        wait_rst(1'b0, 5);
        check(backup_flag_n, 1'b1, "flag shown under low supply");
        repeat (30) @(posedge ref_clk);
        #1 supply_ok = 1'b1;
        wait_rst(1'b1, RST + 10);
        check(n >= RST && n <= RST + 4, 1'b1, "supply reset length");
        check(backup_flag_n, 1'b0, "flag lost after supply dip");
    endtask : sc_uv

    // two goods then a bad restart the count; three goods release the flag
    task automatic sc_recover();
        repeat (2) u_host.service_after(GOOD_AT);
        u_host.service_after(CLOSED / 2);
        wait_rst(1'b0, 4);
        wait_rst(1'b1, RST + 10);
        for (int i = 1; i <= 3; i++) begin
            u_host.service_after(GOOD_AT);
            repeat (2) @(posedge ref_clk);
            #1;
            check(backup_flag_n, (i == 3) ? 1'b1 : 1'b0, "flag release count");
        end
    endtask : sc_recover

    task automatic sc_strap();
        wdog_off = 1'b1;
        saw_low = 1'b0;
        repeat (WDOG + WDOG / 2) @(posedge ref_clk);
        #1;
        check(saw_low, 1'b0, "fault while disabled");
        wdog_off = 1'b0;
    endtask : sc_strap
    ////////////////////////////////////////
    // reset for three cycles, then the scenarios in order
    initial begin
        repeat (3) @(posedge ref_clk);
        #1 arst_n = 1'b1;
        sc_power_up();
        sc_good();
        sc_early();
        sc_late();
        sc_uv();
        sc_recover();
        sc_strap();
        give_verdict();
    end
endmodule : test_window_watchdog_supervisor
`default_nettype wire
